// file: hw/dsie_pkg.sv
// Package for the drive start input evaluation block: timing and widths.
// Assumes a 20 MHz reference clock.
package dsie_pkg;
  localparam int unsigned CLK_HZ         = 20000000;
  localparam int unsigned SCAN_PERIOD_US = 1000;
  localparam int unsigned SCAN_CYCLES    = (CLK_HZ / 1000000) * SCAN_PERIOD_US;
  localparam int unsigned ADC_BITS       = 10;
  localparam int unsigned DIN_LIMIT_HZ   = 500;
  localparam int unsigned RELEASE_LEAD_MS = 2;
  localparam logic        AUTOSTART_OFF  = 1'b0;
  localparam logic        AUTOSTART_ON   = 1'b1;
  typedef enum logic [1:0] {
    DSIE_IDLE    = 2'b00,
    DSIE_RUN     = 2'b01,
    DSIE_FAULT   = 2'b10
  } dsie_state_t;
endpackage

// file: hw/dsie_top.sv
// Drive start input evaluation: scans control terminals every 1 ms and
// decides when the drive runs. Assumes terminal inputs synchronous to i_ref_clk.
//
// Contract
// - Analog setpoint 10-bit value and digital output refresh once per 1 ms scan.
// - Hardware release input sampled once per 1 ms scan, sampled value used.
// - Digital inputs limited to 500 Hz; scan resolves no faster changes.
// - Edge mode starts the drive only on start low-to-high transition.
// - Edge mode: start high after power-on needs low then high first.
// - Level mode starts whenever start is high, also right after power-on.
// - Autostart parameter off selects edge mode, on selects level mode.
// - Autostart restarts drive after power-on and after error reset.
// - Release low keeps output stage locked, motor cannot start.
`timescale 1ns/100ps
module dsie_top #(
  parameter int unsigned SCAN_CYCLES = dsie_pkg::SCAN_CYCLES,
  parameter int unsigned ADC_BITS    = dsie_pkg::ADC_BITS
) (
  input  wire logic                i_ref_clk,
  input  wire logic                i_resetn,
  input  wire logic                i_hardware_release_input,
  input  wire logic                i_start,
  input  wire logic                i_digital_input_zero,
  input  wire logic                i_digital_input_one,
  input  wire logic [ADC_BITS-1:0] i_analog_setpoint_input,
  input  wire logic                i_autostart,
  input  wire logic                i_error,
  input  wire logic                i_error_reset,
  input  wire logic                i_error_restart_allowed,
  input  wire logic                i_stop,
  input  wire logic                i_digital_output_zero,
  output logic                     o_drive_run,
  output logic                     o_stage_enable,
  output logic                     o_scan_tick,
  output logic [ADC_BITS-1:0]      o_analog_setpoint,
  output logic                     o_digital_input_zero,
  output logic                     o_digital_input_one,
  output logic                     o_digital_output_zero,
  output logic                     o_fault
);

  localparam int unsigned CW = $clog2(SCAN_CYCLES);

  // Reset release through two flip-flops
  logic rst_meta_r;
  logic rst_n_r;
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // Scan divider: one-cycle tick every SCAN_CYCLES clocks
  logic [CW-1:0] div_r;
  logic [CW-1:0] div_nxt;
  logic          tick_nxt;
  logic          tick_r;
  always_comb begin
    tick_nxt = (div_r == CW'(SCAN_CYCLES - 1));
    div_nxt  = tick_nxt ? '0 : div_r + 1'b1;
  end

  always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      div_r  <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  // Sampled terminals and run state
  logic                  rel_r;
  logic                  rel_nxt;
  logic                  start_r;
  logic                  start_nxt;
  logic                  edge_r;
  logic                  edge_nxt;
  logic                  din0_r;
  logic                  din0_nxt;
  logic                  din1_r;
  logic                  din1_nxt;
  logic [ADC_BITS-1:0]   ana_r;
  logic [ADC_BITS-1:0]   ana_nxt;
  logic                  dout_r;
  logic                  dout_nxt;
  logic                  run_r;
  logic                  run_nxt;
  logic                  fault_r;
  logic                  fault_nxt;
  dsie_pkg::dsie_state_t st_r;
  dsie_pkg::dsie_state_t st_nxt;

  always_comb begin
    rel_nxt        = rel_r;
    start_nxt      = start_r;
    edge_nxt       = 1'b0;
    din0_nxt       = din0_r;
    din1_nxt       = din1_r;
    ana_nxt        = ana_r;
    dout_nxt       = dout_r;
    if (tick_nxt) begin
      rel_nxt        = i_hardware_release_input;
      edge_nxt       = i_start && !start_r;
      start_nxt      = i_start;
      din0_nxt       = i_digital_input_zero;
      din1_nxt       = i_digital_input_one;
      ana_nxt        = i_analog_setpoint_input;
      dout_nxt       = i_digital_output_zero;
    end
  end

  // Run state: start evaluation, release lock and fault handling
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      dsie_pkg::DSIE_IDLE: begin
        if (i_error) begin
          st_nxt = dsie_pkg::DSIE_FAULT;
        end else if (rel_r) begin
          if (i_autostart == dsie_pkg::AUTOSTART_ON) begin
            if (start_r) begin
              st_nxt = dsie_pkg::DSIE_RUN;
            end
          end else if (edge_r) begin
            st_nxt = dsie_pkg::DSIE_RUN;
          end
        end
      end
      dsie_pkg::DSIE_RUN: begin
        if (i_error) begin
          st_nxt = dsie_pkg::DSIE_FAULT;
        end else if (!rel_r || i_stop) begin
          st_nxt = dsie_pkg::DSIE_IDLE;
        end else if (i_autostart == dsie_pkg::AUTOSTART_ON && !start_r) begin
          st_nxt = dsie_pkg::DSIE_IDLE;
        end
      end
      dsie_pkg::DSIE_FAULT: begin
        // Error reset: autostart may go straight back to run
        if (i_error_reset && !i_error) begin
          if (i_autostart == dsie_pkg::AUTOSTART_ON
              && i_error_restart_allowed
              && rel_r
              && start_r) begin
            st_nxt = dsie_pkg::DSIE_RUN;
          end else begin
            st_nxt = dsie_pkg::DSIE_IDLE;
          end
        end
      end
      default: st_nxt = dsie_pkg::DSIE_IDLE;
    endcase
  end

  // Run and fault flags follow the next state
  always_comb begin
    run_nxt   = (st_nxt == dsie_pkg::DSIE_RUN) && rel_r;
    fault_nxt = (st_nxt == dsie_pkg::DSIE_FAULT);
  end

  // Terminal samples, refreshed at each scan tick
  always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rel_r   <= 1'b0;
      start_r <= 1'b1;
      edge_r  <= 1'b0;
      din0_r  <= 1'b0;
      din1_r  <= 1'b0;
      ana_r   <= '0;
      dout_r  <= 1'b0;
    end else begin
      rel_r   <= rel_nxt;
      start_r <= start_nxt;
      edge_r  <= edge_nxt;
      din0_r  <= din0_nxt;
      din1_r  <= din1_nxt;
      ana_r   <= ana_nxt;
      dout_r  <= dout_nxt;
    end
  end

  // Run state register
  always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      st_r <= dsie_pkg::DSIE_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Run and fault flag registers
  always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      run_r   <= 1'b0;
      fault_r <= 1'b0;
    end else begin
      run_r   <= run_nxt;
      fault_r <= fault_nxt;
    end
  end

  // Start sample is preset high, so a start already high at power-on
  // is no edge; a low scan must come first.
  // Ports come straight from the registers
  always_comb begin
    o_drive_run           = run_r;
    o_stage_enable        = run_r;
    o_scan_tick           = tick_r;
    o_analog_setpoint     = ana_r;
    o_digital_input_zero  = din0_r;
    o_digital_input_one   = din1_r;
    o_digital_output_zero = dout_r;
    o_fault               = fault_r;
  end

endmodule // dsie_top

// file: dv/dsie_checker.sv
// Assertions on the ports of dsie_top.
// Assumes the bench runs SCAN_CYCLES at 8.
`timescale 1ns/100ps
module dsie_checker #(parameter int unsigned ADC_BITS = 10) (
  input wire logic                i_ref_clk,
  input wire logic                i_resetn,
  input wire logic                i_hardware_release_input,
  input wire logic                i_start,
  input wire logic                i_autostart,
  input wire logic                i_error,
  input wire logic                o_drive_run,
  input wire logic                o_stage_enable,
  input wire logic                o_scan_tick,
  input wire logic [ADC_BITS-1:0] o_analog_setpoint,
  input wire logic                o_digital_output_zero,
  input wire logic                o_fault
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  sequence rel_low;
    (!i_hardware_release_input)[*8] ##1 (!i_hardware_release_input)[*3];
  endsequence
  sequence lvl_off;
    (i_autostart && !i_start)[*8] ##1 (i_autostart && !i_start)[*3];
  endsequence
  chk_stage_run: assert property (o_stage_enable == o_drive_run)
    else $error("stage and run differ");
  chk_tick_period: assert property (o_scan_tick |=> !o_scan_tick[*7] ##1 o_scan_tick)
    else $error("scan period wrong");
  chk_analog_scan: assert property (!$stable(o_analog_setpoint) |-> ##[0:1] o_scan_tick)
    else $error("analog off scan");
  chk_dout_scan: assert property (!$stable(o_digital_output_zero) |-> ##[0:1] o_scan_tick)
    else $error("output off scan");
  chk_release_lock: assert property (rel_low |-> !o_stage_enable)
    else $error("stage open without release");
  chk_level_stop: assert property (lvl_off |-> !o_drive_run)
    else $error("level run without start");
  chk_fault_rise: assert property ($rose(i_error) |-> ##[1:2] o_fault)
    else $error("fault late");
  chk_fault_halt: assert property (o_fault[*2] |-> !o_drive_run)
    else $error("run during fault");
endmodule // dsie_checker

// file: dv/dsie_ctrl_model.sv
// Machine controller model driving the control terminals.
// Assumes a free clock; changes land 1 ns after a rising edge.
`timescale 1ns/100ps
module dsie_ctrl_model (
  input  wire logic       i_clk,
  output logic            o_rel,
  output logic            o_start,
  output logic [12:0]     o_io
);
  initial {o_rel, o_start, o_io} = '0;
  task automatic apply(input logic r, input logic s);
    @(posedge i_clk) #1;
    if (r && s && !o_rel && !o_start) begin
      o_rel = r;
      repeat (16) @(posedge i_clk);
      #1;
    end
    o_rel = r;
    o_start = s;
  endtask
  task automatic io(input logic [12:0] v);
    @(posedge i_clk) #1 o_io = v;
    repeat (16) @(posedge i_clk);
    #1;
  endtask
endmodule // dsie_ctrl_model

// file: dv/test_drive_start_input_evaluation.sv
// Self-checking bench for the drive start input evaluation block.
// Assumes dsie_top with SCAN_CYCLES 8 and the controller model.
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module test_drive_start_input_evaluation;
  logic        clk, rstn = 1'h0, auto = 1'h0, err = 1'h0, ers = 1'h0, rok = 1'h0;
  logic        rel, st, run, stg, flt, stop = 1'h0;
  logic [12:0] io, q;
  int          err_total = 0, check_count = 0;
  dsie_top #(.SCAN_CYCLES(8)) i_dsie_top (.i_ref_clk(clk), .i_resetn(rstn),
    .i_hardware_release_input(rel), .i_start(st), .i_digital_input_zero(io[2]),
    .i_digital_input_one(io[1]), .i_analog_setpoint_input(io[12:3]), .i_autostart(auto),
    .i_error(err), .i_error_reset(ers), .i_error_restart_allowed(rok), .i_stop(stop),
    .i_digital_output_zero(io[0]), .o_drive_run(run), .o_stage_enable(stg), .o_scan_tick(),
    .o_analog_setpoint(q[12:3]), .o_digital_input_zero(q[2]), .o_digital_input_one(q[1]),
    .o_digital_output_zero(q[0]), .o_fault(flt));
  dsie_ctrl_model i_dsie_ctrl_model (.i_clk(clk), .o_rel(rel), .o_start(st), .o_io(io));
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  task automatic wt(input int n); repeat (8 * n) @(posedge clk); #1; endtask
  task automatic trm(input logic r, s); i_dsie_ctrl_model.apply(r, s); wt(3); endtask
  task automatic rst(input logic a, s);
    @(posedge clk) #1 rstn = 1'h0;
    auto = a;
    i_dsie_ctrl_model.apply(1'h1, s);
    repeat (6) @(posedge clk);
    #1 rstn = 1'h1;
    wt(4);
  endtask
  task automatic t_edge();
    rst(1'h0, 1'h1);
    `CHK(run, 1'h0)
    trm(1'h1, 1'h0);
    trm(1'h1, 1'h1);
    `CHK(run, 1'h1)
    `CHK(stg, 1'h1)
    @(posedge clk) #1 stop = 1'h1;
    @(posedge clk) #1 stop = 1'h0;
    wt(3);
    `CHK(run, 1'h0)
    trm(1'h1, 1'h0);
    trm(1'h1, 1'h1);
    `CHK(run, 1'h1)
    trm(1'h0, 1'h1);
    `CHK(stg, 1'h0)
    $display("edge test done");
  endtask
  task automatic t_scan();
    for (int k = 0; k < 2; k++) begin
      i_dsie_ctrl_model.io(k ? 13'h0b4a : 13'h1535);
      `CHK(q, k ? 13'h0b4a : 13'h1535)
    end
    $display("scan test done");
  endtask
  task automatic t_level();
    rst(1'h1, 1'h1);
    `CHK(run, 1'h1)
    trm(1'h1, 1'h0);
    `CHK(run, 1'h0)
    trm(1'h1, 1'h1);
    @(posedge clk) #1 err = 1'h1;
    repeat (4) @(posedge clk) #1;
    `CHK({flt, run}, 2'h2)
    @(posedge clk) #1 {err, ers, rok} = 3'h3;
    wt(3);
    `CHK({flt, run}, 2'h1)
    $display("level test done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    t_edge();
    t_scan();
    t_level();
    conclude();
  end
  initial begin
    #100000;
    err_total++;
    conclude();
  end
endmodule // test_drive_start_input_evaluation
bind dsie_top dsie_checker #(.ADC_BITS(ADC_BITS)) i_dsie_checker (
  .i_ref_clk                (i_ref_clk),
  .i_resetn                 (i_resetn),
  .i_hardware_release_input (i_hardware_release_input),
  .i_start                  (i_start),
  .i_autostart              (i_autostart),
  .i_error                  (i_error),
  .o_drive_run              (o_drive_run),
  .o_stage_enable           (o_stage_enable),
  .o_scan_tick              (o_scan_tick),
  .o_analog_setpoint        (o_analog_setpoint),
  .o_digital_output_zero    (o_digital_output_zero),
  .o_fault                  (o_fault)
);
